// ---- src/dso_consts.svh ----
// Constants of the synchronizer control and status register set:
// register offsets, field positions, reset values and timing counts.
// Assumes it is included by bare name from the design files.
`ifndef DSO_CONSTS_SVH
`define DSO_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets on the 7-bit microport address
// ----------------------------------------------------------------
`define DSO_OFS_TIE_CONTROL 7'h00
`define DSO_OFS_REFERENCE_STATUS 7'h01
`define DSO_OFS_OUTPUT_RATE_CONTROL 7'h04
`define DSO_OFS_PHASE_OFFSET_HIGH 7'h06
`define DSO_OFS_PHASE_OFFSET_LOW 7'h07

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSO_BIT_TIE_RUN 0
`define DSO_BIT_PRI_OOR 7
`define DSO_BIT_SEC_OOR 6
`define DSO_BIT_LOCK 5
`define DSO_BIT_HOLDOVER 4
`define DSO_BIT_FREQ_LIM 2
`define DSO_BIT_HS_SELECT 7
`define DSO_BIT_MID_SELECT 6
`define DSO_BIT_OFFSET_EN 3
`define DSO_OFFSET_HIGH_MSB 2
`define DSO_OFFSET_HIGH_KEEP_MSB 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSO_RST_TIE_CONTROL 8'h00
`define DSO_RST_OUTPUT_RATE_CONTROL 8'h00
`define DSO_RST_PHASE_OFFSET_HIGH 4'h0
`define DSO_RST_PHASE_OFFSET_LOW 8'h00
`define DSO_READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Timing: system clock, measurement interval, range limit
// ----------------------------------------------------------------
`define DSO_CLK_HZ 25000000
`define DSO_WINDOW_S 1
`define DSO_WINDOW_CYCLES (`DSO_WINDOW_S * `DSO_CLK_HZ)
`define DSO_RANGE_PPM 12
`define DSO_PPM_DIV 1000000
`define DSO_REF_NOMINAL 2048000

`endif

// ---- src/dso_pkg.sv ----
// Types shared by the synchronizer register set modules.
// Assumes dso_consts.svh carries the numeric constants.
package dso_pkg;
  typedef logic [7:0] dso_byte_t;
  typedef logic [6:0] dso_addr_t;
  typedef logic [10:0] dso_offset_t;
  typedef logic [31:0] dso_count_t;
endpackage

// ---- src/dso_mon_if.sv ----
// Carrier between the register set and one reference range monitor.
// Assumes the top drives window and tick and reads the range flag.
`timescale 1ns/10ps
`default_nettype none
interface dso_mon_if;
  logic window;       // One-cycle pulse closing a measurement interval
  logic ref_tick;     // One-cycle pulse per reference cycle
  logic out_of_range; // Verdict of the last closed interval
  modport mon (input window, input ref_tick, output out_of_range);
  modport ctl (output window, output ref_tick, input out_of_range);
endinterface // dso_mon_if
`default_nettype wire

// ---- src/dso_range_mon.sv ----
// Reference out-of-range monitor: counts reference cycles over one
// measurement interval and flags a count off nominal by more than the limit.
// Assumes ticks are synchronous one-cycle pulses, slower than clock.
`timescale 1ns/10ps
`default_nettype none
`include "dso_consts.svh"
module dso_range_mon
  import dso_pkg::*;
#(
  parameter dso_count_t NOMINAL = dso_count_t'(`DSO_REF_NOMINAL)
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  dso_mon_if.mon mon      // Window, tick and verdict
);
  // ----------------------------------------------------------------
  // Tolerance band in counts
  // ----------------------------------------------------------------
  localparam dso_count_t TOL = dso_count_t'(
    (64'(NOMINAL) * `DSO_RANGE_PPM) / `DSO_PPM_DIV);

  dso_count_t cnt_reg;
  dso_count_t cnt_next;
  logic too_fast;
  logic too_slow;
  logic verdict_reg;

  // Count ticks; a tick on the closing cycle opens the next interval
  assign cnt_next = mon.window ? dso_count_t'(mon.ref_tick)
                               : cnt_reg + dso_count_t'(mon.ref_tick);
  assign too_fast = cnt_reg > (NOMINAL + TOL);
  assign too_slow = (cnt_reg + TOL) < NOMINAL;

  // Counter; verdict only changes at interval close, no flicker
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      verdict_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (mon.window) begin
        verdict_reg <= too_fast | too_slow;
      end
    end
  end

  assign mon.out_of_range = verdict_reg;
endmodule // dso_range_mon
`default_nettype wire

// ---- src/dso_regs.sv ----
// Control and status register set of the network synchronizer PLL,
// reached by a microprocessor over an 8-bit parallel port.
// Assumes port pins and PLL core flags are synchronous to clock.
`timescale 1ns/10ps
`default_nettype none
`include "dso_consts.svh"
module dso_regs
  import dso_pkg::*;
#(
  parameter dso_count_t WINDOW_CYCLES = dso_count_t'(`DSO_WINDOW_CYCLES),
  parameter dso_count_t REF_NOMINAL = dso_count_t'(`DSO_REF_NOMINAL)
) (
  input wire logic clock,                      // 25 MHz system clock
  input wire logic rst_n,                      // Async reset, active low
  input wire logic cs_n,                       // Chip select, active low
  input wire logic ds_n,                       // Data strobe, active low
  input wire logic rw,                         // High read, low write
  input wire dso_addr_t addr,                  // Register address
  input wire dso_byte_t data_in,               // Data bus, input side
  output dso_byte_t data_out,                  // Data bus, output side
  output logic data_oe,                        // Data bus drive enable
  input wire logic pri_ref_tick,               // Primary reference cycle
  input wire logic sec_ref_tick,               // Secondary reference cycle
  input wire logic pll_locked,                 // Core frequency lock
  input wire logic pll_holdover,               // Core in holdover
  input wire logic pll_freq_limit,             // Core at offset limit
  output logic tie_correction_run,             // TIE correction enabled
  output logic diff_155_output_en,             // 155.52 MHz enable
  output logic mid_rate_div4,                  // Mid rate clock divide 4
  output logic mid_rate_select,                // High picks 34.368 MHz
  output logic phase_offset_enable,            // Apply phase offset
  output dso_offset_t phase_offset_count       // Offset word, 60 ns steps
);
  // ----------------------------------------------------------------
  // Microport strobe tracking
  // ----------------------------------------------------------------
  logic access;
  logic access_reg;
  logic access_end;
  logic rd_access;
  logic rw_reg;
  dso_addr_t addr_reg;
  dso_byte_t wdata_reg;

  // An access is chip select and strobe together
  assign access = ~cs_n & ~ds_n;
  assign rd_access = access & rw;
  // Writes commit as the strobe lifts, when data is known settled
  assign access_end = access_reg & ~access;

  // Track the strobe and keep the last address and data it showed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      access_reg <= 1'b0;
      rw_reg <= 1'b1;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      access_reg <= access;
      if (access) begin
        rw_reg <= rw;
        addr_reg <= addr;
        wdata_reg <= data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_commit;
  logic wr_tie;
  logic wr_rate;
  logic wr_off_hi;
  logic wr_off_lo;

  assign wr_commit = access_end & ~rw_reg;
  assign wr_tie = wr_commit & (addr_reg == `DSO_OFS_TIE_CONTROL);
  assign wr_rate = wr_commit & (addr_reg == `DSO_OFS_OUTPUT_RATE_CONTROL);
  assign wr_off_hi = wr_commit & (addr_reg == `DSO_OFS_PHASE_OFFSET_HIGH);
  assign wr_off_lo = wr_commit & (addr_reg == `DSO_OFS_PHASE_OFFSET_LOW);

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  dso_byte_t tie_control_reg;
  dso_byte_t output_rate_control_reg;
  logic [3:0] phase_offset_high_reg;
  dso_byte_t phase_offset_low_reg;

  // Whole bytes are kept, except the offset high byte's low nibble only, so software reads back what it wrote;
  // only the documented bits steer this block's outputs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tie_control_reg <= `DSO_RST_TIE_CONTROL;
      output_rate_control_reg <= `DSO_RST_OUTPUT_RATE_CONTROL;
      phase_offset_high_reg <= `DSO_RST_PHASE_OFFSET_HIGH;
      phase_offset_low_reg <= `DSO_RST_PHASE_OFFSET_LOW;
    end else begin
      if (wr_tie) begin
        tie_control_reg <= wdata_reg;
      end
      if (wr_rate) begin
        output_rate_control_reg <= wdata_reg;
      end
      if (wr_off_hi) begin
        // Upper nibble is reserved and not stored
        phase_offset_high_reg <= wdata_reg[`DSO_OFFSET_HIGH_KEEP_MSB:0];
      end
      if (wr_off_lo) begin
        phase_offset_low_reg <= wdata_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference range monitors and interval divider
  // ----------------------------------------------------------------
  dso_mon_if pri_if ();
  dso_mon_if sec_if ();
  dso_count_t win_cnt_reg;
  logic win_last;
  logic window_reg;

  assign win_last = (win_cnt_reg == WINDOW_CYCLES - dso_count_t'(1));

  // One-second interval divider from the system clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_reg <= '0;
      window_reg <= 1'b0;
    end else begin
      win_cnt_reg <= win_last ? '0 : win_cnt_reg + dso_count_t'(1);
      window_reg <= win_last;
    end
  end

  assign pri_if.window = window_reg;
  assign pri_if.ref_tick = pri_ref_tick;
  assign sec_if.window = window_reg;
  assign sec_if.ref_tick = sec_ref_tick;

  // Both references are judged against the same nominal and interval, each by its own counter
  dso_range_mon #(
    .NOMINAL(REF_NOMINAL)
  ) u_pri_mon (
    .clock(clock),
    .rst_n(rst_n),
    .mon(pri_if.mon)
  );

  dso_range_mon #(
    .NOMINAL(REF_NOMINAL)
  ) u_sec_mon (
    .clock(clock),
    .rst_n(rst_n),
    .mon(sec_if.mon)
  );

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  dso_byte_t status_reg;
  dso_byte_t status_next;

  // Core flags follow live conditions, range flags the last closed interval; nothing latches
  always_comb begin
    status_next = '0;
    status_next[`DSO_BIT_PRI_OOR] = pri_if.out_of_range;
    status_next[`DSO_BIT_SEC_OOR] = sec_if.out_of_range;
    status_next[`DSO_BIT_LOCK] = pll_locked;
    status_next[`DSO_BIT_HOLDOVER] = pll_holdover;
    status_next[`DSO_BIT_FREQ_LIM] = pll_freq_limit;
  end

  // Sampled every cycle so a read sees the flags one cycle old
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  dso_byte_t rd_mux;
  dso_byte_t off_hi_view;

  assign off_hi_view = {4'h0, phase_offset_high_reg};

  // Reading has no side effect on any flag
  always_comb begin
    unique case (addr)
      `DSO_OFS_TIE_CONTROL: rd_mux = tie_control_reg;
      `DSO_OFS_REFERENCE_STATUS: rd_mux = status_reg;
      `DSO_OFS_OUTPUT_RATE_CONTROL: rd_mux = output_rate_control_reg;
      `DSO_OFS_PHASE_OFFSET_HIGH: rd_mux = off_hi_view;
      `DSO_OFS_PHASE_OFFSET_LOW: rd_mux = phase_offset_low_reg;
      default: rd_mux = `DSO_READ_UNMAPPED;
    endcase
  end

  // Bus drive is registered; it stops one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_access;
      data_out <= rd_access ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs to the PLL core and clock generators
  // ----------------------------------------------------------------
  logic hs_output_select;
  logic offset_en_bit;

  assign hs_output_select = output_rate_control_reg[`DSO_BIT_HS_SELECT];
  assign offset_en_bit = phase_offset_high_reg[`DSO_BIT_OFFSET_EN];

  // Registered so every control pin comes straight from a flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tie_correction_run <= 1'b0;
      diff_155_output_en <= 1'b0;
      mid_rate_div4 <= 1'b0;
      mid_rate_select <= 1'b0;
      phase_offset_enable <= 1'b0;
      phase_offset_count <= '0;
    end else begin
      // Low holds the TIE circuit cleared and realigns phase
      tie_correction_run <= tie_control_reg[`DSO_BIT_TIE_RUN];
      diff_155_output_en <= ~hs_output_select;
      mid_rate_div4 <= ~hs_output_select;
      mid_rate_select <=
        output_rate_control_reg[`DSO_BIT_MID_SELECT];
      phase_offset_enable <= offset_en_bit;
      phase_offset_count <= {
        phase_offset_high_reg[`DSO_OFFSET_HIGH_MSB:0],
        phase_offset_low_reg};
    end
  end
endmodule // dso_regs
`default_nettype wire

// ---- sim/dso_regs_asserts.sv ----
// Concurrent checks on the port behaviour of the register set.
// Assumes it is bound to dso_regs and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dso_regs_asserts
  import dso_pkg::*;
#(
  parameter dso_count_t WINDOW_CYCLES = 32'h0000_03e8,
  parameter dso_count_t REF_NOMINAL = 32'h0000_01f4
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic cs_n, // Chip select
  input wire logic ds_n, // Data strobe
  input wire logic rw, // Read or write
  input wire dso_addr_t addr, // Address
  input wire dso_byte_t data_in, // Write data
  input wire dso_byte_t data_out, // Read data
  input wire logic data_oe, // Bus drive
  input wire logic pri_ref_tick, // Primary tick
  input wire logic sec_ref_tick, // Secondary tick
  input wire logic pll_locked, // Lock flag
  input wire logic pll_holdover, // Holdover flag
  input wire logic pll_freq_limit, // Limit flag
  input wire logic tie_correction_run, // TIE run
  input wire logic diff_155_output_en, // Fast output on
  input wire logic mid_rate_div4, // Mid rate divide
  input wire logic mid_rate_select, // Mid rate pick
  input wire logic phase_offset_enable, // Offset on
  input wire dso_offset_t phase_offset_count // Offset word
);
  // --------------------------------------------------------------
  // Decode of the strobe pair
  // --------------------------------------------------------------
  wire acc = !cs_n && !ds_n; // Access seen on an edge
  wire wr_go = acc && !rw; // Write in progress
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------
  // Checks; writes look back to the last edge the strobe was seen
  // --------------------------------------------------------------
  oe_read_a: assert property (acc && rw |=> data_oe)
    else $error("bus not driven on read");
  bus_release_a: assert property (!acc |=> !data_oe && data_out == 8'h00)
    else $error("bus still driven after strobe");
  status_live_a: assert property (acc && rw && addr == 7'h01
    && $stable(pll_locked) && $stable(pll_holdover) && $stable(pll_freq_limit)
    |=> data_out[5:0] == {$past(pll_locked), $past(pll_holdover), 1'b0,
    $past(pll_freq_limit), 2'b00})
    else $error("status byte does not follow core flags");
  rate_pair_a: assert property (diff_155_output_en == mid_rate_div4)
    else $error("fast output and divide disagree");
  tie_write_a: assert property (wr_go && addr == 7'h00
    ##1 !acc |-> ##2 tie_correction_run == $past(data_in[0], 3))
    else $error("tie run did not follow write");
  rate_write_a: assert property (wr_go && addr == 7'h04
    ##1 !acc |-> ##2 mid_rate_select == $past(data_in[6], 3)
    && diff_155_output_en == !$past(data_in[7], 3))
    else $error("rate outputs did not follow write");
  offset_high_a: assert property (wr_go && addr == 7'h06
    ##1 !acc |-> ##2 phase_offset_enable == $past(data_in[3], 3)
    && phase_offset_count[10:8] == $past(data_in[2:0], 3))
    else $error("offset high did not follow write");
  offset_low_a: assert property (wr_go && addr == 7'h07
    ##1 !acc |-> ##2 phase_offset_count[7:0] == $past(data_in, 3))
    else $error("offset low did not follow write");
endmodule // dso_regs_asserts
bind dso_regs dso_regs_asserts #(.WINDOW_CYCLES(WINDOW_CYCLES),
  .REF_NOMINAL(REF_NOMINAL)) chk (.clock(clock), .rst_n(rst_n),
  .cs_n(cs_n), .ds_n(ds_n), .rw(rw), .addr(addr), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .pri_ref_tick(pri_ref_tick),
  .sec_ref_tick(sec_ref_tick), .pll_locked(pll_locked),
  .pll_holdover(pll_holdover), .pll_freq_limit(pll_freq_limit),
  .tie_correction_run(tie_correction_run),
  .diff_155_output_en(diff_155_output_en), .mid_rate_div4(mid_rate_div4),
  .mid_rate_select(mid_rate_select),
  .phase_offset_enable(phase_offset_enable),
  .phase_offset_count(phase_offset_count));
`default_nettype wire

// ---- sim/dso_up_model.sv ----
// Microprocessor model on the 8-bit parallel port of the register set.
// Assumes the port is sampled on rising edges; it drives on falling ones.
`timescale 1ns/10ps
`default_nettype none
module dso_up_model
  import dso_pkg::*;
(
  input wire logic clock, // System clock
  output var logic cs_n, // Chip select
  output var logic ds_n, // Data strobe
  output var logic rw, // Read or write
  output var dso_addr_t addr, // Address
  output var dso_byte_t data_in, // Write data
  input wire dso_byte_t data_out, // Read data
  input wire logic data_oe // Bus drive
);
  // --------------------------------------------------------------
  // Bus cycles; released lines show the inverse so nothing stale passes
  // --------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    ds_n = 1'b1;
    rw = 1'b1;
    addr = 7'h7f;
    data_in = 8'hff;
  end
  // Write, strobe held len cycles; returns once the pins have followed
  task automatic wr(input dso_addr_t a, input dso_byte_t d, input int len);
    @(negedge clock);
    cs_n = 1'b0;
    ds_n = 1'b0;
    rw = 1'b0;
    addr = a;
    data_in = d;
    repeat (len) @(negedge clock);
    cs_n = 1'b1;
    ds_n = 1'b1;
    addr = ~a;
    data_in = ~d;
    repeat (2) @(negedge clock);
  endtask
  // Read, data taken one edge after the strobe was seen
  task automatic rd(input dso_addr_t a, output dso_byte_t d, output logic oe);
    @(negedge clock);
    cs_n = 1'b0;
    ds_n = 1'b0;
    rw = 1'b1;
    addr = a;
    @(negedge clock);
    d = data_out;
    oe = data_oe;
    cs_n = 1'b1;
    ds_n = 1'b1;
    addr = ~a;
    @(negedge clock);
  endtask
endmodule // dso_up_model
`default_nettype wire

// ---- sim/dso_regs_tb.sv ----
// Self-checking bench for the register set, with a short interval.
// Assumes dso_up_model drives the port and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module dso_regs_tb
  import dso_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, ds_n, rw, data_oe, roe;
  dso_addr_t addr;
  dso_byte_t data_in, data_out, rdata;
  logic pri_ref_tick = 1'b0;
  logic sec_ref_tick = 1'b0;
  logic pll_locked = 1'b0;
  logic pll_holdover = 1'b0;
  logic pll_freq_limit = 1'b0;
  logic tie_correction_run, diff_155_output_en, mid_rate_div4;
  logic mid_rate_select, phase_offset_enable;
  dso_offset_t phase_offset_count;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int pri_per = 2;
  int sec_per = 2;
  always #20 clock = ~clock;
  // Short interval; 500 ticks nominal leaves no slack, so one tick trips
  dso_regs #(.WINDOW_CYCLES(32'h0000_03e8), .REF_NOMINAL(32'h0000_01f4)) uut (
    .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .ds_n(ds_n), .rw(rw),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .pri_ref_tick(pri_ref_tick), .sec_ref_tick(sec_ref_tick),
    .pll_locked(pll_locked), .pll_holdover(pll_holdover),
    .pll_freq_limit(pll_freq_limit), .tie_correction_run(tie_correction_run),
    .diff_155_output_en(diff_155_output_en), .mid_rate_div4(mid_rate_div4),
    .mid_rate_select(mid_rate_select),
    .phase_offset_enable(phase_offset_enable),
    .phase_offset_count(phase_offset_count));
  dso_up_model up (.clock(clock), .cs_n(cs_n), .ds_n(ds_n), .rw(rw),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // Reference ticks, one every pri_per or sec_per cycles
  always @(negedge clock) begin
    cyc <= cyc + 1;
    pri_ref_tick <= (cyc % pri_per) == 0;
    sec_ref_tick <= (cyc % sec_per) == 0;
  end
  // --------------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------------
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input dso_addr_t a, input dso_byte_t exp);
    up.rd(a, rdata, roe);
    check(11'(roe), 11'h001);
    check(11'(rdata), 11'(exp));
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    check(11'(tie_correction_run), 11'h000);
    check(11'(diff_155_output_en), 11'h001);
    check(11'(mid_rate_div4), 11'h001);
    check(phase_offset_count, 11'h000);
    rdchk(7'h00, 8'h00);
    rdchk(7'h07, 8'h00);
    rdchk(7'h02, 8'h00);
  endtask
  // Slow strobe on the first write, then back to zero
  task automatic t_tie();
    up.wr(7'h00, 8'h01, 3);
    check(11'(tie_correction_run), 11'h001);
    rdchk(7'h00, 8'h01);
    up.wr(7'h00, 8'h00, 1);
    check(11'(tie_correction_run), 11'h000);
  endtask
  // All four rate codes; low six bits kept zero by software
  task automatic t_rate();
    for (int i = 0; i < 4; i++) begin
      up.wr(7'h04, {i[1:0], 6'h00}, 1);
      check(11'(diff_155_output_en), 11'(!i[1]));
      check(11'(mid_rate_div4), 11'(!i[1]));
      check(11'(mid_rate_select), 11'(i[0]));
      rdchk(7'h04, {i[1:0], 6'h00});
    end
  endtask
  // Each byte lands on its own; upper four bits kept zero by software
  task automatic t_offset();
    up.wr(7'h06, 8'h0d, 1);
    up.wr(7'h07, 8'ha5, 1);
    check(11'(phase_offset_enable), 11'h001);
    check(phase_offset_count, 11'h5a5);
    rdchk(7'h06, 8'h0d);
    rdchk(7'h07, 8'ha5);
    up.wr(7'h06, 8'h07, 1);
    check(11'(phase_offset_enable), 11'h000);
    check(phase_offset_count, 11'h7a5);
  endtask
  // Every flag pattern, read twice; a write to the status byte is lost
  task automatic t_status();
    up.wr(7'h01, 8'hff, 1);
    for (int i = 0; i < 8; i++) begin
      {pll_locked, pll_holdover, pll_freq_limit} = i[2:0];
      repeat (2) @(negedge clock);
      rdchk(7'h01, {2'b00, i[2], i[1], 1'b0, i[0], 2'b00});
      rdchk(7'h01, {2'b00, i[2], i[1], 1'b0, i[0], 2'b00});
    end
    {pll_locked, pll_holdover, pll_freq_limit} = 3'h0;
  endtask
  // Fast secondary, then slow primary; verdict after two full intervals
  task automatic t_oor();
    sec_per = 1;
    repeat (2100) @(negedge clock);
    rdchk(7'h01, 8'h40);
    pri_per = 3;
    sec_per = 2;
    repeat (2100) @(negedge clock);
    rdchk(7'h01, 8'h80);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_reset();
    t_tie();
    t_rate();
    t_offset();
    t_status();
    t_oor();
    results();
  end
  // Watchdog well past the roughly 4400 cycles the scenarios take
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    results();
  end
endmodule // dso_regs_tb
`default_nettype wire
